// ---- hdl/pmb_cmd_bank.sv ----
// Vendor command bank: peaks, NV settings, fault log and special commands
`timescale 1ns/1ps
module pmb_cmd_bank #(
    parameter logic [15:0] PART_ID = pmb_pkg::PART_ID_DFLT
) (
    input  wire logic                       CLK,
    input  wire logic                       RST_B,
    input  wire logic [7:0]                 CMD_CODE,
    input  wire logic                       CMD_WR,
    input  wire logic                       CMD_RD,
    input  wire logic                       CMD_SEND,
    input  wire logic [15:0]                CMD_WDATA,
    input  wire logic                       PAGE,
    output logic      [15:0]                CMD_RDATA,
    output logic                            CMD_ACK,
    output logic                            CMD_NACK,
    input  wire logic                       STORE_ALL,
    input  wire logic                       RESTORE_ALL,
    input  wire pmb_pkg::pmb_meas_t         MEAS,
    input  wire logic                       MEAS_VALID,
    input  wire logic [15:0]                PADS,
    input  wire logic [7:0]                 COMMON,
    output logic      [pmb_pkg::LOG_AW-1:0] LOG_IDX,
    input  wire logic [7:0]                 LOG_BYTE,
    output logic                            LOG_BUSY,
    output logic                            MEM_MISMATCH,
    output logic                            FULL_RESET_REQ,
    output pmb_pkg::pmb_nv_t                CFG
);
    import pmb_pkg::*;

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic signed [47:0] l11_val(input logic [15:0] w);
        logic signed [47:0] m;
        logic signed [5:0]  e;
        m = {{37{w[10]}}, w[10:0]};
        e = {w[15], w[15:11]};
        l11_val = m <<< (6'(e + 6'sd16));
    endfunction : l11_val

    function automatic logic peak_gt(input logic l16,
                                     input logic [15:0] a,
                                     input logic [15:0] b);
        peak_gt = l16 ? (a > b) : (l11_val(a) > l11_val(b));
    endfunction : peak_gt

    function automatic logic is_l16(input int i);
        is_l16 = (i == PK_VOUT) || (i == PK_VOUT + 1);
    endfunction : is_l16

    function automatic logic code_rw(input logic [7:0] c);
        code_rw = (c == CMD_RETRY)  || (c == CMD_RESTART) ||
                  (c == CMD_DEV_ADDR) || (c == CMD_PWM_CFG) ||
                  (c == CMD_TEMPCO) || (c == CMD_SLOPE) ||
                  (c == CMD_OFFSET) || (c == CMD_RAIL_ADDR);
    endfunction : code_rw

    function automatic logic code_ro(input logic [7:0] c);
        code_ro = (c == CMD_IOUT_PEAK) || (c == CMD_VOUT_PEAK) ||
                  (c == CMD_VIN_PEAK)  || (c == CMD_TEXT_PEAK) ||
                  (c == CMD_TINT_PEAK) || (c == CMD_PADS) ||
                  (c == CMD_PART_ID)   || (c == CMD_LOG_READ) ||
                  (c == CMD_COMMON);
    endfunction : code_ro

    function automatic logic code_send(input logic [7:0] c);
        code_send = (c == CMD_PEAK_CLR)  || (c == CMD_LOG_STORE) ||
                    (c == CMD_LOG_ERASE) || (c == CMD_COMPARE) ||
                    (c == CMD_FULL_RESET);
    endfunction : code_send

    // ************************************************************
    // Request capture
    // ************************************************************
    logic [7:0]  q_code_r;
    logic        q_wr_r;
    logic        q_rd_r;
    logic        q_send_r;
    logic [15:0] q_wdata_r;
    logic        q_page_r;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            q_code_r  <= 8'h00;
            q_wr_r    <= 1'b0;
            q_rd_r    <= 1'b0;
            q_send_r  <= 1'b0;
            q_wdata_r <= 16'h0000;
            q_page_r  <= 1'b0;
        end else begin
            q_code_r  <= CMD_CODE;
            q_wr_r    <= CMD_WR;
            q_rd_r    <= CMD_RD;
            q_send_r  <= CMD_SEND;
            q_wdata_r <= CMD_WDATA;
            q_page_r  <= PAGE;
        end
    end

    // ************************************************************
    // Decode
    // ************************************************************
    pmb_log_st_t log_st_r;
    pmb_log_st_t log_st_nxt;
    logic        busy;
    logic        log_cmd;
    logic        wr_ok;
    logic        rd_ok;
    logic        send_ok;
    logic        clr_fire;
    logic        store_go;
    logic        erase_go;
    logic        cmp_fire;
    logic        full_fire;
    logic        reload;

    assign busy      = (log_st_r != LOG_IDLE);
    // Log commands are refused while the walker runs; it owns the memory port
    assign log_cmd   = (q_code_r == CMD_LOG_STORE) ||
                       (q_code_r == CMD_LOG_ERASE) ||
                       (q_code_r == CMD_LOG_READ);
    assign wr_ok     = q_wr_r & code_rw(q_code_r);
    assign rd_ok     = q_rd_r & (code_rw(q_code_r) | code_ro(q_code_r)) &
                       ~(busy & log_cmd);
    assign send_ok   = q_send_r & code_send(q_code_r) & ~(busy & log_cmd);
    assign clr_fire  = send_ok & (q_code_r == CMD_PEAK_CLR);
    assign store_go  = send_ok & (q_code_r == CMD_LOG_STORE);
    assign erase_go  = send_ok & (q_code_r == CMD_LOG_ERASE);
    assign cmp_fire  = send_ok & (q_code_r == CMD_COMPARE);
    assign full_fire = send_ok & (q_code_r == CMD_FULL_RESET);
    assign reload    = RESTORE_ALL | full_fire;

    // ************************************************************
    // Working and stored settings
    // ************************************************************
    pmb_nv_t work_r;
    pmb_nv_t work_nxt;
    pmb_nv_t shadow_r;

    always_comb begin
        work_nxt = work_r;
        if (reload) begin
            work_nxt = shadow_r;
        end else if (wr_ok) begin
            case (q_code_r)
                CMD_RETRY:     work_nxt.retry[q_page_r]   = q_wdata_r;
                CMD_RESTART:   work_nxt.restart[q_page_r] = q_wdata_r;
                CMD_DEV_ADDR:  work_nxt.addr = q_wdata_r[7:0];
                CMD_RAIL_ADDR: work_nxt.rail[q_page_r] = q_wdata_r[7:0];
                CMD_PWM_CFG:   work_nxt.pwm = q_wdata_r[7:0];
                CMD_TEMPCO:    work_nxt.tempco[q_page_r]  = q_wdata_r;
                CMD_SLOPE:     work_nxt.slope[q_page_r]   = q_wdata_r;
                CMD_OFFSET:    work_nxt.offset[q_page_r]  = q_wdata_r;
                default:       work_nxt = work_r;
            endcase
        end
    end

    // Power-up loads defaults into both copies: the stored image
    // has no life across power loss in this model
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            work_r   <= NV_DFLT;
            shadow_r <= NV_DFLT;
        end else begin
            work_r <= work_nxt;
            if (STORE_ALL) begin
                shadow_r <= work_r;
            end
        end
    end

    assign CFG = work_r;

    // ************************************************************
    // Peak trackers
    // ************************************************************
    // Unpacked so each generate slot owns its own variable
    logic [15:0] pk_r [N_PEAK];

    for (genvar i = 0; i < N_PEAK; i++) begin : g_peak
        localparam logic [15:0] FLOOR = is_l16(i) ? PK_L16_FLOOR
                                                  : PK_L11_FLOOR;
        wire logic [15:0] base = (clr_fire | full_fire) ? FLOOR
                                                        : pk_r[i];
        // A sample in the clearing cycle survives the clear
        wire logic take = MEAS_VALID & peak_gt(is_l16(i), MEAS[i], base);
        always_ff @(posedge CLK or negedge RST_B) begin
            if (!RST_B) begin
                pk_r[i] <= FLOOR;
            end else begin
                pk_r[i] <= take ? MEAS[i] : base;
            end
        end
    end

    // ************************************************************
    // Fault log walker
    // ************************************************************
    logic [LOG_AW-1:0] idx_r;
    logic [LOG_AW-1:0] rptr_r;
    logic [7:0]        mem_dout;
    logic              mem_we;
    logic [7:0]        mem_wdata;
    logic              idx_last;

    assign idx_last  = (idx_r == LOG_AW'(LOG_DEPTH - 1));
    assign mem_we    = busy;
    assign mem_wdata = (log_st_r == LOG_STORE) ? LOG_BYTE
                                               : LOG_ERASED;

    always_comb begin
        log_st_nxt = log_st_r;
        case (log_st_r)
            LOG_IDLE: begin
                if (store_go) begin
                    log_st_nxt = LOG_STORE;
                end else if (erase_go) begin
                    log_st_nxt = LOG_ERASE;
                end
            end
            LOG_STORE,
            LOG_ERASE: begin
                if (idx_last) begin
                    log_st_nxt = LOG_IDLE;
                end
            end
            default: log_st_nxt = LOG_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            log_st_r <= LOG_IDLE;
            idx_r    <= '0;
            rptr_r   <= '0;
        end else begin
            log_st_r <= log_st_nxt;
            idx_r    <= busy ? idx_r + 1'b1 : '0;
            if (rd_ok && q_code_r == CMD_LOG_READ) begin
                rptr_r <= rptr_r + 1'b1;
            end else if (q_rd_r || q_wr_r || q_send_r) begin
                rptr_r <= '0;
            end
        end
    end

    assign LOG_IDX  = idx_r;
    assign LOG_BUSY = busy;

    pmb_log_mem u_log_mem (
        .clk   (CLK),
        .we    (mem_we),
        .waddr (idx_r),
        .wdata (mem_wdata),
        .raddr (rptr_r),
        .rdata (mem_dout)
    );

    // ************************************************************
    // Read mux and answers
    // ************************************************************
    logic [15:0] rd_mux;

    always_comb begin
        case (q_code_r)
            CMD_IOUT_PEAK: rd_mux = pk_r[PK_IOUT + 32'(q_page_r)];
            CMD_VOUT_PEAK: rd_mux = pk_r[PK_VOUT + 32'(q_page_r)];
            CMD_VIN_PEAK:  rd_mux = pk_r[PK_VIN];
            CMD_TEXT_PEAK: rd_mux = pk_r[PK_TEXT + 32'(q_page_r)];
            CMD_TINT_PEAK: rd_mux = pk_r[PK_TINT];
            CMD_RETRY:     rd_mux = work_r.retry[q_page_r];
            CMD_RESTART:   rd_mux = work_r.restart[q_page_r];
            CMD_PADS:      rd_mux = PADS;
            CMD_DEV_ADDR:  rd_mux = {8'h00, work_r.addr};
            CMD_PART_ID:   rd_mux = PART_ID;
            CMD_LOG_READ:  rd_mux = {8'h00, mem_dout};
            CMD_COMMON:    rd_mux = {8'h00, COMMON};
            CMD_PWM_CFG:   rd_mux = {8'h00, work_r.pwm};
            CMD_TEMPCO:    rd_mux = work_r.tempco[q_page_r];
            CMD_SLOPE:     rd_mux = work_r.slope[q_page_r];
            CMD_OFFSET:    rd_mux = work_r.offset[q_page_r];
            CMD_RAIL_ADDR: rd_mux = {8'h00, work_r.rail[q_page_r]};
            default:       rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            CMD_RDATA      <= 16'h0000;
            CMD_ACK        <= 1'b0;
            CMD_NACK       <= 1'b0;
            MEM_MISMATCH   <= 1'b0;
            FULL_RESET_REQ <= 1'b0;
        end else begin
            if (rd_ok) begin
                CMD_RDATA <= rd_mux;
            end
            CMD_ACK        <= wr_ok | rd_ok | send_ok;
            CMD_NACK       <= (q_wr_r | q_rd_r | q_send_r) &
                              ~(wr_ok | rd_ok | send_ok);
            if (cmp_fire) begin
                MEM_MISMATCH <= (work_r != shadow_r);
            end
            FULL_RESET_REQ <= full_fire;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_store_run;
        (log_st_r == LOG_STORE)[*8];
    endsequence

    property p_peak_hold;
        @(posedge CLK) disable iff (!RST_B)
        !clr_fire && !full_fire |=>
            l11_val(pk_r[PK_VIN]) >= l11_val($past(pk_r[PK_VIN]));
    endproperty
    a_peak_hold: assert property (p_peak_hold)
        else $error("vin peak dropped without a clear");

    property p_peak_clear;
        @(posedge CLK) disable iff (!RST_B)
        clr_fire && !MEAS_VALID |=> pk_r[PK_VIN] == PK_L11_FLOOR;
    endproperty
    a_peak_clear: assert property (p_peak_clear)
        else $error("peak clear left a stale value");

    property p_per_channel_flag_write;
        @(posedge CLK) disable iff (!RST_B)
        wr_ok && q_code_r == CMD_RETRY && !reload |=>
            work_r.retry[$past(q_page_r)] == $past(q_wdata_r);
    endproperty
    a_per_channel_flag_write: assert property (p_per_channel_flag_write)
        else $error("retry write missed the selected channel");

    property p_store_walk;
        @(posedge CLK) disable iff (!RST_B)
        store_go && !busy |=> s_store_run ##25 !busy;
    endproperty
    a_store_walk: assert property (p_store_walk)
        else $error("log store did not take the full depth");

    property p_erase_walk;
        @(posedge CLK) disable iff (!RST_B)
        erase_go && !busy |=>
            (mem_we && mem_wdata == LOG_ERASED) ##32 !busy;
    endproperty
    a_erase_walk: assert property (p_erase_walk)
        else $error("log erase wrote wrong data or length");

    property p_log_read;
        @(posedge CLK) disable iff (!RST_B)
        rd_ok && q_code_r == CMD_LOG_READ |=>
            CMD_ACK && CMD_RDATA == {8'h00, $past(mem_dout)};
    endproperty
    a_log_read: assert property (p_log_read)
        else $error("log byte read back wrong");

    property p_compare;
        @(posedge CLK) disable iff (!RST_B)
        cmp_fire |=> MEM_MISMATCH == ($past(work_r) != $past(shadow_r));
    endproperty
    a_compare: assert property (p_compare)
        else $error("compare result does not match settings");

    property p_full_reset;
        @(posedge CLK) disable iff (!RST_B)
        full_fire |=> FULL_RESET_REQ && work_r == $past(shadow_r);
    endproperty
    a_full_reset: assert property (p_full_reset)
        else $error("full reset did not reload settings");

    property p_part_id;
        @(posedge CLK) disable iff (!RST_B)
        rd_ok && q_code_r == CMD_PART_ID |=> CMD_RDATA == PART_ID;
    endproperty
    a_part_id: assert property (p_part_id)
        else $error("identification word changed");

endmodule : pmb_cmd_bank

// ---- hdl/pmb_pkg.sv ----
// Package: command codes, defaults and types of the vendor command bank
package pmb_pkg;

    // ************************************************************
    // Command codes
    // ************************************************************
    localparam logic [7:0] CMD_IOUT_PEAK  = 8'hd7;
    localparam logic [7:0] CMD_RETRY      = 8'hdb;
    localparam logic [7:0] CMD_RESTART    = 8'hdc;
    localparam logic [7:0] CMD_VOUT_PEAK  = 8'hdd;
    localparam logic [7:0] CMD_VIN_PEAK   = 8'hde;
    localparam logic [7:0] CMD_TEXT_PEAK  = 8'hdf;
    localparam logic [7:0] CMD_PEAK_CLR   = 8'he3;
    localparam logic [7:0] CMD_PADS       = 8'he5;
    localparam logic [7:0] CMD_DEV_ADDR   = 8'he6;
    localparam logic [7:0] CMD_PART_ID    = 8'he7;
    localparam logic [7:0] CMD_LOG_STORE  = 8'hea;
    localparam logic [7:0] CMD_LOG_ERASE  = 8'hec;
    localparam logic [7:0] CMD_LOG_READ   = 8'hee;
    localparam logic [7:0] CMD_COMMON     = 8'hef;
    localparam logic [7:0] CMD_COMPARE    = 8'hf0;
    localparam logic [7:0] CMD_TINT_PEAK  = 8'hf4;
    localparam logic [7:0] CMD_PWM_CFG    = 8'hf5;
    localparam logic [7:0] CMD_TEMPCO     = 8'hf6;
    localparam logic [7:0] CMD_SLOPE      = 8'hf8;
    localparam logic [7:0] CMD_OFFSET     = 8'hf9;
    localparam logic [7:0] CMD_RAIL_ADDR  = 8'hfa;
    localparam logic [7:0] CMD_FULL_RESET = 8'hfd;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [15:0] RETRY_DFLT   = 16'hfabc;
    localparam logic [15:0] RESTART_DFLT = 16'hfbe8;
    localparam logic [7:0]  ADDR_DFLT    = 8'h4f;
    localparam logic [7:0]  RAIL_DFLT    = 8'h80;
    localparam logic [7:0]  PWM_DFLT     = 8'h14;
    localparam logic [15:0] TEMPCO_DFLT  = 16'h0f3c;
    localparam logic [15:0] SLOPE_DFLT   = 16'h4000;
    localparam logic [15:0] OFFSET_DFLT  = 16'h8000;
    // Most negative linear value, so any first sample wins
    localparam logic [15:0] PK_L11_FLOOR = 16'h7c00;
    localparam logic [15:0] PK_L16_FLOOR = 16'h0000;
    // Arbitrary identification value
    localparam logic [15:0] PART_ID_DFLT = 16'h5a5a;
    localparam logic [7:0]  LOG_ERASED   = 8'hff;

    // ************************************************************
    // Sizes and tracker slots
    // ************************************************************
    localparam int LOG_DEPTH = 32;
    localparam int LOG_AW    = 5;
    localparam int N_PEAK    = 8;
    localparam int PK_IOUT   = 0;
    localparam int PK_VOUT   = 2;
    localparam int PK_VIN    = 4;
    localparam int PK_TEXT   = 5;
    localparam int PK_TINT   = 7;

    // ************************************************************
    // Types
    // ************************************************************
    typedef logic [N_PEAK-1:0][15:0] pmb_meas_t;

    typedef struct packed {
        logic [1:0][15:0] retry;
        logic [1:0][15:0] restart;
        logic [7:0]       addr;
        logic [1:0][7:0]  rail;
        logic [7:0]       pwm;
        logic [1:0][15:0] tempco;
        logic [1:0][15:0] slope;
        logic [1:0][15:0] offset;
    } pmb_nv_t;

    localparam pmb_nv_t NV_DFLT = '{
        retry:   {2{RETRY_DFLT}},
        restart: {2{RESTART_DFLT}},
        addr:    ADDR_DFLT,
        rail:    {2{RAIL_DFLT}},
        pwm:     PWM_DFLT,
        tempco:  {2{TEMPCO_DFLT}},
        slope:   {2{SLOPE_DFLT}},
        offset:  {2{OFFSET_DFLT}}
    };

    typedef enum logic [1:0] {
        LOG_IDLE  = 2'b00,
        LOG_STORE = 2'b01,
        LOG_ERASE = 2'b10
    } pmb_log_st_t;

endpackage : pmb_pkg

// ---- hdl/pmb_log_mem.sv ----
// Fault log store: one write port, registered read port
`timescale 1ns/1ps
module pmb_log_mem (
    input  wire logic                       clk,
    input  wire logic                       we,
    input  wire logic [pmb_pkg::LOG_AW-1:0] waddr,
    input  wire logic [7:0]                 wdata,
    input  wire logic [pmb_pkg::LOG_AW-1:0] raddr,
    output logic      [7:0]                 rdata
);
    import pmb_pkg::*;

    logic [7:0] mem [LOG_DEPTH];

    // No reset on the array; contents are defined by an erase
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule : pmb_log_mem

// ---- dv/pmb_log_src.sv ----
// Partner model: operating fault log bytes offered to the store walk
`timescale 1ns/1ps
module pmb_log_src (
    input  wire logic [pmb_pkg::LOG_AW-1:0] log_idx,
    output logic      [7:0]                 log_byte
);
    // Pattern differs byte to byte so a slipped index shows up
    assign log_byte = {3'b000, log_idx} * 8'h07 + 8'h03;
endmodule : pmb_log_src

// ---- dv/pmb_cmd_bank_test.sv ----
// Self-checking bench of the vendor command bank
`timescale 1ns/1ps
module pmb_cmd_bank_test;
    import pmb_pkg::*;
    typedef struct packed {logic a; logic c; logic [15:0] d;} pmb_note_t;
    logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, snd = 1'b0;
    logic page = 1'b0, sta = 1'b0, rsa = 1'b0, mv = 1'b0;
    logic [7:0] code = 8'h00, common = 8'h00, lb;
    logic [15:0] wdata = 16'h0000, pads = 16'h0000, v, rdata;
    logic [31:0] seed = 32'h6467, r;
    pmb_meas_t meas = '0, pk;
    logic ack, nack, busy, mism, frr;
    pmb_nv_t cfg;
    logic [LOG_AW-1:0] idx;
    int failures = 0, comparisons = 0, cycles = 0;
    pmb_note_t notes[$], n;
    logic [7:0] rw_c [8] = '{CMD_RETRY, CMD_RESTART, CMD_DEV_ADDR,
        CMD_RAIL_ADDR, CMD_PWM_CFG, CMD_TEMPCO, CMD_SLOPE, CMD_OFFSET};
    logic [15:0] rw_d [8] = '{RETRY_DFLT, RESTART_DFLT, {8'h00, ADDR_DFLT},
        {8'h00, RAIL_DFLT}, {8'h00, PWM_DFLT}, TEMPCO_DFLT, SLOPE_DFLT,
        OFFSET_DFLT};
    logic rw_pg [8] = '{1, 1, 0, 1, 0, 1, 1, 1};
    logic rw_by [8] = '{0, 0, 1, 1, 1, 0, 0, 0};
    logic [7:0] pk_c [6] = '{CMD_IOUT_PEAK, CMD_IOUT_PEAK, CMD_VOUT_PEAK,
        CMD_VIN_PEAK, CMD_TEXT_PEAK, CMD_TINT_PEAK};
    logic pk_p [6] = '{0, 1, 1, 0, 1, 0};
    int pk_s [6] = '{0, 1, 3, 4, 6, 7};
    logic [15:0] ex [8][2];
    pmb_cmd_bank pmb_cmd_bank_inst (.CLK(clk), .RST_B(rst_b),
        .CMD_CODE(code), .CMD_WR(wr), .CMD_RD(rd), .CMD_SEND(snd),
        .CMD_WDATA(wdata), .PAGE(page), .CMD_RDATA(rdata), .CMD_ACK(ack),
        .CMD_NACK(nack), .STORE_ALL(sta), .RESTORE_ALL(rsa), .MEAS(meas),
        .MEAS_VALID(mv), .PADS(pads), .COMMON(common), .LOG_IDX(idx),
        .LOG_BYTE(lb), .LOG_BUSY(busy), .MEM_MISMATCH(mism),
        .FULL_RESET_REQ(frr), .CFG(cfg));
    pmb_log_src pmb_log_src_inst (.log_idx(idx), .log_byte(lb));
    initial forever #10 clk = ~clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task conclude();
        if (failures == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    task check(string w, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask : check
    // Strobe lasts one cycle; answer is seen at the second falling edge
    task op(logic [1:0] k, logic [7:0] c, logic p, logic [15:0] w,
            logic a, logic ch, logic [15:0] d);
        notes.push_back(pmb_note_t'{a, ch, d});
        @(negedge clk);
        code = c; page = p; wdata = w;
        wr = (k == 2'd0); rd = (k == 2'd1); snd = (k == 2'd2);
        @(negedge clk);
        wr = 1'b0; rd = 1'b0; snd = 1'b0;
        @(negedge clk);
    endtask : op
    task automatic pulse(ref logic s);
        @(negedge clk); s = 1'b1;
        @(negedge clk); s = 1'b0;
    endtask : pulse
    task idle();
        for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
        check("log_busy", 16'h0000, {15'h0000, busy});
    endtask : idle
    // ************************************************************
    // Answer watcher and hang guard
    // ************************************************************
    always @(negedge clk) if (ack === 1'b1 || nack === 1'b1) begin
        if (notes.size() == 0) check("answer", 16'h0000, 16'h0001);
        else begin
            n = notes.pop_front();
            check("ack", {15'h0000, n.a}, {15'h0000, ack});
            check("nack", {15'h0000, ~n.a}, {15'h0000, nack});
            if (n.c) check("rdata", n.d, rdata);
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        r = xs(); pads = r[15:0]; common = r[23:16];
        for (int i = 0; i < 8; i++) for (int p = 0; p < 2; p++) begin
            ex[i][p] = rw_d[i];
            op(2'd1, rw_c[i], p[0], 16'h0, 1, 1, rw_d[i]);
        end
        for (int i = 0; i < 8; i++) begin
            r = xs(); v = rw_by[i] ? {8'h00, r[7:0]} : r[15:0];
            op(2'd0, rw_c[i], 1'b1, v, 1, 0, 16'h0);
            ex[i][1] = v;
            if (!rw_pg[i]) ex[i][0] = v;
        end
        check("cfg retry", ex[0][1], cfg.retry[1]);
        check("cfg pwm", ex[4][0], {8'h00, cfg.pwm});
        for (int i = 0; i < 8; i++) for (int p = 0; p < 2; p++)
            op(2'd1, rw_c[i], p[0], 16'h0, 1, 1, ex[i][p]);
        repeat (2) op(2'd1, CMD_PART_ID, 0, 16'h0, 1, 1, PART_ID_DFLT);
        op(2'd0, CMD_PART_ID, 0, 16'h1234, 0, 0, 16'h0);
        op(2'd1, 8'hd8, 0, 16'h0, 0, 0, 16'h0);
        op(2'd2, CMD_RETRY, 0, 16'h0, 0, 0, 16'h0);
        op(2'd1, CMD_PADS, 0, 16'h0, 1, 1, pads);
        op(2'd1, CMD_COMMON, 0, 16'h0, 1, 1, {8'h00, common});
        op(2'd2, CMD_COMPARE, 0, 16'h0, 1, 0, 16'h0);
        check("mismatch flag", 16'h0001, {15'h0000, mism});
        pulse(sta);
        op(2'd2, CMD_COMPARE, 0, 16'h0, 1, 0, 16'h0);
        check("mismatch flag", 16'h0000, {15'h0000, mism});
        op(2'd0, CMD_OFFSET, 0, ~ex[7][0], 1, 0, 16'h0);
        pulse(rsa);
        op(2'd1, CMD_OFFSET, 0, 16'h0, 1, 1, ex[7][0]);
        op(2'd0, CMD_OFFSET, 0, ~ex[7][0], 1, 0, 16'h0);
        op(2'd2, CMD_FULL_RESET, 0, 16'h0, 1, 0, 16'h0);
        check("full reset", 16'h0001, {15'h0000, frr});
        op(2'd1, CMD_OFFSET, 0, 16'h0, 1, 1, ex[7][0]);
        for (int s = 0; s < 8; s++) begin
            r = xs();
            pk[s] = (s == 2 || s == 3) ? r[15:0] : {6'h00, r[9:0]};
        end
        meas = pk; pulse(mv);
        // A smaller second sample must not displace the held peak
        for (int s = 0; s < 8; s++) meas[s] = pk[s] >> 1;
        pulse(mv);
        for (int i = 0; i < 6; i++)
            op(2'd1, pk_c[i], pk_p[i], 16'h0, 1, 1, pk[pk_s[i]]);
        op(2'd2, CMD_PEAK_CLR, 0, 16'h0, 1, 0, 16'h0);
        for (int i = 0; i < 6; i++) begin
            v = (i == 2) ? PK_L16_FLOOR : PK_L11_FLOOR;
            op(2'd1, pk_c[i], pk_p[i], 16'h0, 1, 1, v);
        end
        for (int e = 0; e < 2; e++) begin
            op(2'd2, e ? CMD_LOG_ERASE : CMD_LOG_STORE, 0, 16'h0, 1, 0, 0);
            op(2'd2, CMD_LOG_ERASE, 0, 16'h0, 0, 0, 16'h0);
            idle();
            for (int i = 0; i < 32; i++) begin
                v = e ? {8'h00, LOG_ERASED} : {8'h00, i[7:0] * 8'h07 + 8'h03};
                op(2'd1, CMD_LOG_READ, 0, 16'h0, 1, 1, v);
            end
        end
        repeat (3) @(negedge clk);
        conclude();
    end
endmodule : pmb_cmd_bank_test
